// [rtl/becr_top.sv]
// Error capture register bank of a bus bridge, reached over APB.
// Assumes event inputs are single-cycle pulses synchronous to clk and that
// the line and address inputs are valid in the cycle of the event.
//
// What this block does
// - Loading the exception capture sets the exception capture-valid bit.
// - Capture on error end, 2eVME slave end, or 2eSST last-word-invalid.
// - Exception while capture-valid is set keeps contents, sets overflow.
// - Writing one to exception clear clears valid and overflow; reads zero.
// - Odd flag set for last-word-invalid or odd-beat 2eVME termination.
// - Fast slave-terminated flag set when a slave ended the fast transfer.
// - Bus-error flag set when the transfer ended with error termination.
// - LWORD, WRITE and IACK lines are recorded in bits 18, 17, 16.
// - Data strobes DS1 and DS0 are recorded in bits 15 and 14.
// - Address modifier in bits 13 to 8, extended modifier in 7 to 0.
// - PCI error stores address bits 63..32 while its valid is clear.
// - PCI error stores address bits 31..0 while its valid is clear.
// - PCI error stores attribute-phase AD bits while its valid is clear.
// - Exception also stores address 63..32 and 31..1, same gating.
// - PCI capture sets PCI valid; writing PCI clear one clears it.
// - PCI error while valid keeps contents, sets overflow; clear clears it.
module becr_top
    import becr_pkg::*;
(
    input wire logic clk, // 125 MHz clock.
    input wire logic sys_rst, // Asynchronous reset, active high.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped addresses.
    output logic irq, // Level interrupt.
    input wire logic vmeErrTerm, // Master transfer ended with bus error.
    input wire logic vmeSlaveTerm, // Slave ended a 2eVME or 2eSST transfer.
    input wire logic vmeLastInvalid, // 2eSST ended with last word invalid.
    input wire logic vmeTwoeVme, // Current transfer uses 2eVME.
    input wire logic vmeOddBeat, // Termination fell on an odd beat.
    input wire logic vmeLword, // LWORD line asserted.
    input wire logic vmeWrite, // WRITE line asserted.
    input wire logic vmeIack, // IACK line asserted.
    input wire logic vmeDs1, // DS1 strobe asserted.
    input wire logic vmeDs0, // DS0 strobe asserted.
    input wire logic [5:0] vmeAm, // Address modifier lines.
    input wire logic [7:0] vmeXam, // Extended address modifier lines.
    input wire logic [63:0] vmeAddr, // Address of the failed transfer.
    input wire logic pciErr, // PCI/X bus error pulse.
    input wire logic [63:0] pciAddr, // Address of the failed PCI/X transfer.
    input wire logic [31:0] pciAttr // AD bits of the attribute phase.
);

    becr_state_t st;
    becr_state_t next_st;
    logic wrAcc;
    logic vEvt;
    logic vClr;
    logic vCap;
    logic pClr;
    logic pCap;

    ////////////////////////////////////////////////////////////////////////
    // Read decode; the top result bit flags an unmapped address.
    function automatic logic [32:0] readWord(input becr_state_t s,
                                              input logic [11:0] a);
        logic [31:0] w;
        logic bad;
        w = RST_WORD;
        bad = 1'b0;
        unique case (a)
            OFF_VADDR_HI: w = s.vAddrHi;
            OFF_VADDR_LO: w = {s.vAddrLo, 1'b0};
            OFF_VATTR: begin
                w[BIT_VALID] = s.vValid;
                w[BIT_OVF] = s.vOvf;
                w[BIT_ODD] = s.vOdd;
                w[BIT_SLV] = s.vSlv;
                w[BIT_BERR] = s.vBerr;
                w[BIT_LWORD] = s.vLword;
                w[BIT_WRITE] = s.vWrite;
                w[BIT_IACK] = s.vIack;
                w[BIT_DS1] = s.vDs1;
                w[BIT_DS0] = s.vDs0;
                w[AM_LSB +: AM_W] = s.vAm;
                w[XAM_LSB +: XAM_W] = s.vXam;
            end
            OFF_PADDR_HI: w = s.pAddrHi;
            OFF_PADDR_LO: w = s.pAddrLo;
            OFF_PATTR_PH: w = s.pAttr;
            OFF_PSTAT: begin
                w[BIT_VALID] = s.pValid;
                w[BIT_OVF] = s.pOvf;
            end
            OFF_INT_STAT: w[INT_W-1:0] = s.intStat;
            OFF_INT_CLR: w = RST_WORD;
            OFF_INT_EN: w[INT_W-1:0] = s.intEn;
            default: bad = 1'b1;
        endcase
        return {bad, w};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for capture, interrupt and bus slave.
    always_comb begin
        next_st = st;
        wrAcc = psel && penable && st.ready && pwrite;
        vEvt = vmeErrTerm || vmeSlaveTerm || vmeLastInvalid;
        vClr = wrAcc && (paddr == OFF_VATTR) && pwdata[BIT_CLR];
        pClr = wrAcc && (paddr == OFF_PSTAT) && pwdata[BIT_CLR];
        // A capture in the clearing cycle starts a fresh record, so the
        // event is never lost to a simultaneous clear.
        vCap = vEvt && (!st.vValid || vClr);
        pCap = pciErr && (!st.pValid || pClr);

        // Exception capture-valid and overflow.
        if (vClr) begin
            next_st.vValid = 1'b0;
            next_st.vOvf = 1'b0;
        end
        if (vCap) begin
            next_st.vValid = 1'b1;
            next_st.vOdd = vmeLastInvalid ||
                ((vmeSlaveTerm || vmeErrTerm) && vmeTwoeVme &&
                 vmeOddBeat);
            next_st.vSlv = vmeSlaveTerm;
            next_st.vBerr = vmeErrTerm;
            next_st.vLword = vmeLword;
            next_st.vWrite = vmeWrite;
            next_st.vIack = vmeIack;
            next_st.vDs1 = vmeDs1;
            next_st.vDs0 = vmeDs0;
            next_st.vAm = vmeAm;
            next_st.vXam = vmeXam;
            next_st.vAddrHi = vmeAddr[63:32];
            next_st.vAddrLo = vmeAddr[31:1];
        end else if (vEvt) begin
            next_st.vOvf = 1'b1;
        end

        // PCI/X capture-valid and overflow.
        if (pClr) begin
            next_st.pValid = 1'b0;
            next_st.pOvf = 1'b0;
        end
        if (pCap) begin
            next_st.pValid = 1'b1;
            next_st.pAddrHi = pciAddr[63:32];
            next_st.pAddrLo = pciAddr[31:0];
            next_st.pAttr = pciAttr;
        end else if (pciErr) begin
            next_st.pOvf = 1'b1;
        end

        // Interrupt enable, then sticky status where a set beats a clear.
        if (wrAcc && paddr == OFF_INT_EN) begin
            next_st.intEn = pwdata[INT_W-1:0];
        end
        if (wrAcc && paddr == OFF_INT_CLR) begin
            next_st.intStat = st.intStat & ~pwdata[INT_W-1:0];
        end
        next_st.intStat[INT_VCAP] = next_st.intStat[INT_VCAP] | vCap;
        next_st.intStat[INT_VOVF] =
            next_st.intStat[INT_VOVF] | (vEvt && !vCap);
        next_st.intStat[INT_PCAP] = next_st.intStat[INT_PCAP] | pCap;
        next_st.intStat[INT_POVF] =
            next_st.intStat[INT_POVF] | (pciErr && !pCap);
        next_st.irq = |(next_st.intStat & next_st.intEn);

        // One wait-free access phase: data is prepared in the setup cycle.
        next_st.ready = psel && !penable;
        if (psel && !penable) begin
            {next_st.slverr, next_st.rdata} = readWord(st, paddr);
            if (pwrite) begin
                next_st.rdata = RST_WORD;
            end
        end else begin
            next_st.slverr = 1'b0;
            next_st.rdata = RST_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; every field clears on reset.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks on capture, overflow, clear and the bus answer.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence vOvfCase;
        st.vValid && vEvt && !vClr;
    endsequence

    sequence pOvfCase;
        st.pValid && pciErr && !pClr;
    endsequence

    sequence apbSetup;
        psel && !penable;
    endsequence

    AST_VCAP_VALID: assert property (vCap |=> st.vValid)
        else $error("Exception capture did not set valid.");
    AST_VCAP_IDLE: assert property (
        !st.vValid && vEvt |=> st.vValid && st.vXam == $past(vmeXam))
        else $error("Idle exception was not captured.");
    AST_VOVF_HOLD: assert property (
        vOvfCase |=> st.vOvf && $stable(st.vAm) &&
        $stable(st.vAddrHi))
        else $error("Overflow changed the captured record.");
    AST_VCLR: assert property (
        vClr && !vEvt |=> !st.vValid && !st.vOvf)
        else $error("Exception clear did not clear valid and overflow.");
    AST_VODD: assert property (
        vCap && vmeLastInvalid |=> st.vOdd && st.intStat[INT_VCAP])
        else $error("Odd termination flag not set.");
    AST_VFLAGS: assert property (
        vCap |=> st.vSlv == $past(vmeSlaveTerm) &&
        st.vBerr == $past(vmeErrTerm))
        else $error("Termination kind flags wrong.");
    AST_VLINES: assert property (
        vCap |=> {st.vLword, st.vWrite, st.vIack, st.vDs1, st.vDs0} ==
        $past({vmeLword, vmeWrite, vmeIack, vmeDs1, vmeDs0}))
        else $error("Captured line states wrong.");
    AST_PCAP: assert property (
        pCap |=> st.pValid && st.pAttr == $past(pciAttr) &&
        st.pAddrLo == $past(pciAddr[31:0]))
        else $error("PCI capture wrong.");
    AST_POVF: assert property (
        pOvfCase |=> st.pOvf && $stable(st.pAddrHi))
        else $error("PCI overflow changed the record.");
    AST_APB_ANSWER: assert property (
        apbSetup ##1 (psel && penable) |-> pready ##1 !pready)
        else $error("APB answer not given in the first access cycle.");

    ////////////////////////////////////////////////////////////////////////
    // Further checks on the captured fields and on the held records.

    // A capture of either side in this cycle.
    sequence vCapCase;
        vCap;
    endsequence

    sequence pCapCase;
        pCap;
    endsequence

    // A clear with no competing event, so the record must empty.
    sequence pClrOnly;
        pClr && !pciErr;
    endsequence

    // No capture this cycle, so every captured field must hold still.
    sequence vQuiet;
        !vCap;
    endsequence

    sequence pQuiet;
        !pCap;
    endsequence

    // The slave-ended flag follows the slave termination of the event.
    AST_VSLV: assert property (vCapCase |=> st.vSlv == $past(vmeSlaveTerm))
        else $error("Fast slave-terminated flag wrong.");

    // Both data strobes are taken in the event cycle.
    AST_VDS: assert property (
        vCapCase |=> {st.vDs1, st.vDs0} == $past({vmeDs1, vmeDs0}))
        else $error("Captured data strobes wrong.");

    // Modifier lines are taken whole, never partly.
    AST_VAM: assert property (
        vCapCase |=> st.vAm == $past(vmeAm) &&
        st.vXam == $past(vmeXam))
        else $error("Captured address modifiers wrong.");

    // The failed address is split over the two address registers.
    AST_VADDR: assert property (
        vCapCase |=> st.vAddrHi == $past(vmeAddr[63:32]) &&
        st.vAddrLo == $past(vmeAddr[31:1]))
        else $error("Captured exception address wrong.");

    // An overflow leaves the rest of the record alone and keeps valid.
    AST_VOVF_KEEP: assert property (
        vOvfCase |=> st.vValid && $stable(st.vXam) &&
        $stable(st.vAddrLo) && st.intStat[INT_VOVF])
        else $error("Exception overflow disturbed the record.");

    // Without a capture no write can reach the exception record.
    AST_VHOLD: assert property (
        vQuiet |=> $stable(st.vAm) && $stable(st.vXam) &&
        $stable(st.vAddrHi) && $stable(st.vAddrLo))
        else $error("Exception record changed without a capture.");

    // The upper PCI/X address half lands in its own register.
    AST_PADDR_HI: assert property (
        pCapCase |=> st.pAddrHi == $past(pciAddr[63:32]))
        else $error("PCI upper address wrong.");

    // The lower PCI/X address half lands in its own register.
    AST_PADDR_LO: assert property (
        pCapCase |=> st.pAddrLo == $past(pciAddr[31:0]))
        else $error("PCI lower address wrong.");

    // A clear with no new error empties valid and overflow.
    AST_PCLR: assert property (pClrOnly |=> !st.pValid && !st.pOvf)
        else $error("PCI clear did not clear valid and overflow.");

    // A PCI/X overflow leaves the attribute word and low address alone.
    AST_POVF_KEEP: assert property (
        pOvfCase |=> $stable(st.pAttr) && $stable(st.pAddrLo) &&
        st.intStat[INT_POVF])
        else $error("PCI overflow disturbed the record.");

    // Without a capture no write can reach the PCI/X record.
    AST_PHOLD: assert property (
        pQuiet |=> $stable(st.pAddrHi) && $stable(st.pAddrLo) &&
        $stable(st.pAttr))
        else $error("PCI record changed without a capture.");

    // Read data is zero whenever no answer is on the bus, so a stale
    // word can never be mistaken for a fresh one.
    AST_RDATA_IDLE: assert property (!pready |-> prdata == RST_WORD)
        else $error("Read data not zero outside an answer.");

    // The interrupt line always mirrors the enabled status bits.
    AST_IRQ_LEVEL: assert property (irq == |(st.intStat & st.intEn))
        else $error("Interrupt line does not match enabled status.");

endmodule

// [rtl/becr_pkg.sv]
// Constants for the bus error capture register bank.
// Assumes a 12-bit APB byte address inside the configuration register group.
package becr_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets inside the configuration register group.
    localparam logic [11:0] OFF_VADDR_HI = 12'h260;
    localparam logic [11:0] OFF_VADDR_LO = 12'h264;
    localparam logic [11:0] OFF_VATTR = 12'h268;
    localparam logic [11:0] OFF_PADDR_HI = 12'h270;
    localparam logic [11:0] OFF_PADDR_LO = 12'h274;
    localparam logic [11:0] OFF_PATTR_PH = 12'h278;
    localparam logic [11:0] OFF_PSTAT = 12'h280;
    localparam logic [11:0] OFF_INT_STAT = 12'h290;
    localparam logic [11:0] OFF_INT_CLR = 12'h294;
    localparam logic [11:0] OFF_INT_EN = 12'h298;

    // Field positions shared by the exception attribute word and the PCI/X status word.
    localparam int BIT_VALID = 31;
    localparam int BIT_OVF = 30;
    localparam int BIT_CLR = 29;
    // Fields of the exception attribute word.
    localparam int BIT_ODD = 21;
    localparam int BIT_SLV = 20;
    localparam int BIT_BERR = 19;
    localparam int BIT_LWORD = 18;
    localparam int BIT_WRITE = 17;
    localparam int BIT_IACK = 16;
    localparam int BIT_DS1 = 15;
    localparam int BIT_DS0 = 14;
    localparam int AM_LSB = 8;
    localparam int AM_W = 6;
    localparam int XAM_LSB = 0;
    localparam int XAM_W = 8;

    // Interrupt event bits.
    localparam int INT_W = 4;
    localparam int INT_VCAP = 0;
    localparam int INT_VOVF = 1;
    localparam int INT_PCAP = 2;
    localparam int INT_POVF = 3;

    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_INT = 4'h0;

    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [31:0] vAddrHi;
        logic [30:0] vAddrLo;
        logic vValid;
        logic vOvf;
        logic vOdd;
        logic vSlv;
        logic vBerr;
        logic vLword;
        logic vWrite;
        logic vIack;
        logic vDs1;
        logic vDs0;
        logic [5:0] vAm;
        logic [7:0] vXam;
        logic [31:0] pAddrHi;
        logic [31:0] pAddrLo;
        logic [31:0] pAttr;
        logic pValid;
        logic pOvf;
        logic [3:0] intStat;
        logic [3:0] intEn;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } becr_state_t;

endpackage

// [bench/becr_far_model.sv]
// Far-side model: a VME slave and a PCI/X agent that end transfers badly.
// Assumes its tasks are called just after a rising edge of clk.
module becr_far_model (
    input wire logic clk, // Bench clock.
    output logic vmeErrTerm, // Error end pulse.
    output logic vmeSlaveTerm, // Slave end pulse.
    output logic vmeLastInvalid, // Last word invalid pulse.
    output logic vmeTwoeVme, // Fast protocol level.
    output logic vmeOddBeat, // Odd beat level.
    output logic vmeLword, // LWORD line.
    output logic vmeWrite, // WRITE line.
    output logic vmeIack, // IACK line.
    output logic vmeDs1, // DS1 strobe.
    output logic vmeDs0, // DS0 strobe.
    output logic [5:0] vmeAm, // Address modifier.
    output logic [7:0] vmeXam, // Extended modifier.
    output logic [63:0] vmeAddr, // Failed address.
    output logic pciErr, // PCI/X error pulse.
    output logic [63:0] pciAddr, // PCI/X failed address.
    output logic [31:0] pciAttr // Attribute phase bits.
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // Idle level and data lines show the inverse of the last value, so a late sample shows; event pulses idle at zero.
    initial begin
        {vmeErrTerm, vmeSlaveTerm, vmeLastInvalid, pciErr} = 4'h0;
        {vmeTwoeVme, vmeOddBeat, vmeLword, vmeWrite} = 4'h0;
        {vmeIack, vmeDs1, vmeDs0, vmeAm, vmeXam} = 17'h0;
        {vmeAddr, pciAddr, pciAttr} = 160'h0;
    end
    // One failed VME transfer: ev is error, slave end, last invalid.
    task automatic vme(input logic [2:0] ev, input logic [6:0] ln,
            input logic [5:0] am, input logic [7:0] xam,
            input logic [63:0] ad);
        {vmeErrTerm, vmeSlaveTerm, vmeLastInvalid} <= ev;
        {vmeTwoeVme, vmeOddBeat, vmeLword, vmeWrite} <= ln[6:3];
        {vmeIack, vmeDs1, vmeDs0, vmeAm, vmeXam} <= {ln[2:0], am, xam};
        vmeAddr <= ad;
        @(posedge clk);
        {vmeErrTerm, vmeSlaveTerm, vmeLastInvalid} <= 3'h0;
        {vmeTwoeVme, vmeOddBeat, vmeLword, vmeWrite} <= ~ln[6:3];
        {vmeIack, vmeDs1, vmeDs0, vmeAm, vmeXam} <= ~{ln[2:0], am, xam};
        vmeAddr <= ~ad;
    endtask
    // One failed PCI/X transfer.
    task automatic pci(input logic [63:0] ad, input logic [31:0] at);
        pciErr <= 1'b1;
        {pciAddr, pciAttr} <= {ad, at};
        @(posedge clk);
        pciErr <= 1'b0;
        {pciAddr, pciAttr} <= ~{ad, at};
    endtask
endmodule

// [bench/tb.sv]
// Self-checking bench of the error capture register bank.
// Assumes the far-side model in becr_far_model drives all event inputs.
module tb import becr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
n_fail++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic vmeErrTerm, vmeSlaveTerm, vmeLastInvalid, vmeTwoeVme, vmeOddBeat;
    logic vmeLword, vmeWrite, vmeIack, vmeDs1, vmeDs0, pciErr, e;
    logic [5:0] vmeAm;
    logic [7:0] vmeXam;
    logic [31:0] pciAttr;
    logic [63:0] vmeAddr, pciAddr;
    int n_fail = 0;
    int samples_checked = 0;
    becr_top u_dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .irq, .vmeErrTerm,
        .vmeSlaveTerm, .vmeLastInvalid, .vmeTwoeVme, .vmeOddBeat, .vmeLword,
        .vmeWrite, .vmeIack, .vmeDs1, .vmeDs0, .vmeAm, .vmeXam, .vmeAddr,
        .pciErr, .pciAddr, .pciAttr);
    becr_far_model u_far (.clk, .vmeErrTerm, .vmeSlaveTerm, .vmeLastInvalid,
        .vmeTwoeVme, .vmeOddBeat, .vmeLword, .vmeWrite, .vmeIack, .vmeDs1,
        .vmeDs0, .vmeAm, .vmeXam, .vmeAddr, .pciErr, .pciAddr, .pciAttr);
    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; an idle cycle follows so strobes never double up.
    task automatic apb(input logic [11:0] a, input logic w,
            input logic [31:0] d);
        int k;
        k = 0;
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        if (k == 20) n_fail++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        `CHK(r, x)
    endtask
    task automatic chkIrq(input logic x);
        @(posedge clk);
        @(posedge clk);
        `CHK(irq, x)
        @(posedge clk);
    endtask
    // Exception word: f = valid, overflow, odd, slave, error.
    function automatic logic [31:0] aw(logic [4:0] f, logic [4:0] ln,
            logic [5:0] am, logic [7:0] xam);
        return {f[4:3], 8'h0, f[2:0], ln, am, xam};
    endfunction
    task automatic results();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The run needs about 150 cycles; the limit is far beyond that.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 10; i++) rd(12'h260 + 12'(4 * i), 32'h0);
        apb(12'h298, 1'b1, 32'hf);
        u_far.vme(3'b100, 7'h76, 6'h2d, 8'ha5, 64'h1234_5678_9abc_def1);
        rd(12'h268, aw(5'h15, 5'h16, 6'h2d, 8'ha5));
        rd(12'h260, 32'h1234_5678);
        rd(12'h264, 32'h9abc_def0);
        chkIrq(1'b1);
        u_far.vme(3'b011, 7'h01, 6'h12, 8'h3c, 64'h0);
        rd(12'h268, aw(5'h1d, 5'h16, 6'h2d, 8'ha5));
        rd(12'h264, 32'h9abc_def0);
        rd(12'h290, 32'h3);
        apb(12'h268, 1'b1, 32'h0);
        rd(12'h268, aw(5'h1d, 5'h16, 6'h2d, 8'ha5));
        apb(12'h268, 1'b1, 32'h2000_0000);
        rd(12'h268, aw(5'h05, 5'h16, 6'h2d, 8'ha5));
        apb(12'h294, 1'b1, 32'hf);
        chkIrq(1'b0);
        apb(12'h298, 1'b1, 32'h0);
        u_far.vme(3'b011, 7'h01, 6'h12, 8'h3c, 64'h0);
        rd(12'h268, aw(5'h16, 5'h01, 6'h12, 8'h3c));
        rd(12'h290, 32'h1);
        chkIrq(1'b0);
        apb(12'h298, 1'b1, 32'h1);
        chkIrq(1'b1);
        u_far.pci(64'hfedc_ba98_7654_3210, 32'h0a0b_0c0d);
        rd(12'h270, 32'hfedc_ba98);
        rd(12'h274, 32'h7654_3210);
        rd(12'h278, 32'h0a0b_0c0d);
        rd(12'h280, 32'h8000_0000);
        u_far.pci(64'h1, 32'h2);
        apb(12'h270, 1'b1, 32'hffff_ffff);
        rd(12'h270, 32'hfedc_ba98);
        rd(12'h278, 32'h0a0b_0c0d);
        rd(12'h280, 32'hc000_0000);
        rd(12'h290, 32'hd);
        apb(12'h280, 1'b1, 32'h2000_0000);
        rd(12'h280, 32'h0);
        rd(12'h294, 32'h0);
        apb(12'h294, 1'b1, 32'hf);
        chkIrq(1'b0);
        apb(12'h2a0, 1'b0, 32'h0);
        `CHK(e, 1'b1)
        results();
    end
endmodule
